//--- rtl/cit_pkg.sv
// Constants shared by the counter and interlock timing block.
// Assumes a single 100 MHz system clock and no software-visible registers.
package cit_pkg;
   // ----------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int INCR_NS = 200;
   localparam int INCR_CYC = INCR_NS / CLK_PERIOD_NS;
   localparam int LEVEL_NS = 400;
   localparam int LEVEL_CYC = LEVEL_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Counter shape
   // ----------------------------------------------------------------
   localparam int STEPS = 7;
   localparam int STEP_W = 3;
   localparam logic [STEP_W-1:0] FIRST_STEP = 3'h0;
   localparam logic [STEP_W-1:0] LAST_STEP = 3'h6;
   localparam logic [STEPS-1:0] LVL_NONE = 7'h00;
   localparam logic [STEPS-1:0] LVL_FIRST = 7'h01;
   // ----------------------------------------------------------------
   // Counter population and shared devices
   // ----------------------------------------------------------------
   localparam int NCNT = 3;
   localparam int DEV_W = 2;
   localparam logic [NCNT*DEV_W-1:0] DEV_MAP = 6'h10;
endpackage

//--- rtl/cit_cnt_if.sv
// Link between the interlock control and one cycle counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cit_cnt_if;
   logic pulse;
   logic start;
   logic run;
   logic wrap;
   logic [cit_pkg::STEPS-1:0] lvl;
   modport ctr (input pulse, input start, output run, output wrap, output lvl);
   modport ctl (output pulse, output start, input run, input wrap, input lvl);
endinterface

//--- rtl/cit_counter.sv
// One cycle counter: steps 0 to 6 on clock pulses and decodes time levels.
// Assumes start is offered only on a pulse while idle or on the last step.
`timescale 1ns/100ps
module cit_counter (
   input wire logic clk,
   input wire logic sys_rst,
   cit_cnt_if.ctr bus
);
   typedef struct packed {
      logic run;
      logic [cit_pkg::STEP_W-1:0] st;
      logic [cit_pkg::STEPS-1:0] lvl;
   } cit_ctr_t;

   cit_ctr_t s;
   cit_ctr_t next_s;

   // ----------------------------------------------------------------
   // Counter register driver
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (bus.pulse) begin
         if (bus.start) begin
            next_s.run = 1'b1;
            next_s.st = cit_pkg::FIRST_STEP;
         end else if (s.run) begin
            if (s.st == cit_pkg::LAST_STEP) begin
               next_s.run = 1'b0;
               next_s.st = cit_pkg::FIRST_STEP;
            end else begin
               next_s.st = s.st + 3'h1;
            end
         end
      end
      next_s.lvl = next_s.run ? (cit_pkg::LVL_FIRST << next_s.st) : cit_pkg::LVL_NONE;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.run = s.run;
   assign bus.wrap = s.run & (s.st == cit_pkg::LAST_STEP);
   assign bus.lvl = s.lvl;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_step_advance;
      @(posedge clk) disable iff (sys_rst)
      (bus.pulse && s.run && !bus.start && s.st != cit_pkg::LAST_STEP) |=> (s.st == $past(s.st) + 3'h1) && s.run;
   endproperty
   a_step_advance: assert property (p_step_advance) else $error("counter did not advance one step");

   property p_hold_between;
      @(posedge clk) disable iff (sys_rst)
      !bus.pulse |=> $stable(s.st) && $stable(s.run);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("counter moved without a pulse");
endmodule

//--- rtl/cit_timing.sv
// Central timing: clock pulses, cycle counters, interlocks, drivers, synchronizers.
// Assumes requests and control levels come from synchronous control logic.
`timescale 1ns/100ps
module cit_timing #(
   parameter int NCNT = cit_pkg::NCNT,
   parameter int INCR_PER_LEVEL = cit_pkg::LEVEL_CYC / cit_pkg::INCR_CYC,
   parameter logic [NCNT*cit_pkg::DEV_W-1:0] DEV_MAP = cit_pkg::DEV_MAP
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [NCNT-1:0] req,
   input wire logic [NCNT-1:0] ev_async,
   input wire logic [NCNT*cit_pkg::STEPS-1:0] ctl_lvl,
   output logic clock_pulse,
   output logic [NCNT*cit_pkg::STEPS-1:0] time_lvl,
   output logic [NCNT*cit_pkg::STEPS-1:0] gated_pulse,
   output logic [NCNT-1:0] cnt_busy,
   output logic [NCNT-1:0] interlock,
   output logic [NCNT-1:0] sync_lvl
);
   localparam int NSTEP = cit_pkg::STEPS;
   localparam int PULSE_CYC = cit_pkg::INCR_CYC * INCR_PER_LEVEL;
   localparam int PW = $clog2(PULSE_CYC);
   localparam logic [PW-1:0] PRE_LAST = PW'(PULSE_CYC - 1);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic tick;
      logic [NCNT-1:0] pend;
      logic [NCNT-1:0] s1;
      logic [NCNT-1:0] s2;
      logic [NCNT-1:0] s3;
      logic [NCNT-1:0] caught;
      logic [NCNT-1:0] slvl;
      logic [NCNT*NSTEP-1:0] gp;
   } cit_state_t;

   cit_state_t s;
   cit_state_t next_s;
   logic [NCNT-1:0] grant;
   logic [NCNT-1:0] run;
   logic [NCNT-1:0] wrap;
   logic [NCNT*NSTEP-1:0] tl;

   // ----------------------------------------------------------------
   // Cycle counters
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCNT; g++) begin : gen_cnt
         cit_cnt_if cif ();
         assign cif.pulse = s.tick;
         assign cif.start = grant[g];
         assign run[g] = cif.run;
         assign wrap[g] = cif.wrap;
         assign tl[g*NSTEP +: NSTEP] = cif.lvl;
         cit_counter u_cnt (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(cif.ctr)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interlock start decision
   // ----------------------------------------------------------------
   // A counter on its last step counts as free, so a pending request
   // restarts it back to back without losing a pulse.
   always_comb begin
      logic ok;
      logic taken;
      ok = 1'b0;
      grant = '0;
      taken = 1'b0;
      for (int i = 0; i < NCNT; i++) begin
         ok = s.tick & s.pend[i] & ~(run[i] & ~wrap[i]);
         for (int j = 0; j < NCNT; j++) begin
            if (j != i && DEV_MAP[j*cit_pkg::DEV_W +: cit_pkg::DEV_W] == DEV_MAP[i*cit_pkg::DEV_W +: cit_pkg::DEV_W]
                && ((run[j] & ~wrap[j]) | grant[j])) begin
               ok = 1'b0;
            end
         end
         if (ok && !taken) begin
            grant[i] = 1'b1;
            taken = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pulse source, interlocks, synchronizers, register drivers
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.tick = (s.pre == PRE_LAST);
      next_s.pre = (s.pre == PRE_LAST) ? '0 : s.pre + PW'(1);
      next_s.s1 = ev_async;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // A new edge beats the clear at a pulse, so no event is lost.
      next_s.caught = (s.caught & ~{NCNT{s.tick}}) | (s.s2 & ~s.s3);
      // Level changes only at a pulse.
      if (s.tick) begin
         next_s.slvl = s.caught;
      end
      next_s.pend = (s.pend & ~grant) | req | (s.slvl & {NCNT{s.tick}});
      // Control and time levels with pulse.
      // Control level ANDed with time level.
      next_s.gp = ctl_lvl & tl & {NCNT*NSTEP{s.tick}};
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign gated_pulse = s.gp;
   assign time_lvl = tl;
   assign cnt_busy = run;
   assign interlock = s.pend;
   assign sync_lvl = s.slvl;
   assign clock_pulse = s.tick;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [PW-1:0] gap;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Starting one below zero lines the first gap up with later ones.
         gap <= '1;
      end else begin
         gap <= s.tick ? '0 : gap + PW'(1);
      end
   end

   property p_pulse_period;
      (s.tick && $past(s.tick, 2) == 1'b0 && gap != '0) |-> gap == PW'(PULSE_CYC - 1);
   endproperty
   a_pulse_period: assert property (p_pulse_period) else $error("pulse period wrong");

   property p_gp_on_pulse;
      (|gated_pulse) |-> $past(s.tick);
   endproperty
   a_gp_on_pulse: assert property (p_gp_on_pulse) else $error("gated pulse without clock pulse");

   property p_gp_qualified;
      (|gated_pulse) |-> ((gated_pulse & ~($past(tl) & $past(ctl_lvl))) == '0);
   endproperty
   a_gp_qualified: assert property (p_gp_qualified) else $error("gated pulse not qualified");

   property p_one_start;
      $onehot0(grant);
   endproperty
   a_one_start: assert property (p_one_start) else $error("two counters started together");

   property p_start_needs_lock;
      (|grant) |-> ((grant & ~s.pend) == '0) && s.tick;
   endproperty
   a_start_needs_lock: assert property (p_start_needs_lock) else $error("start without interlock");

   property p_level_change;
      $changed(tl) |-> $past(s.tick);
   endproperty
   a_level_change: assert property (p_level_change) else $error("time level moved off a pulse");

   property p_sync_change;
      $changed(s.slvl) |-> $past(s.tick);
   endproperty
   a_sync_change: assert property (p_sync_change) else $error("sync level not pulse coincident");

   property p_lock_cleared;
      (|grant) && ((grant & (req | (s.slvl & {NCNT{s.tick}}))) == '0) |=> ((s.pend & $past(grant)) == '0);
   endproperty
   a_lock_cleared: assert property (p_lock_cleared) else $error("interlock not cleared on start");

   generate
      for (g = 0; g < NCNT; g++) begin : gen_chk
         property p_stop_at_end;
            (s.tick && wrap[g] && !grant[g]) |=> !run[g] ##1 !run[g];
         endproperty
         a_stop_at_end: assert property (p_stop_at_end) else $error("counter ran on unrequested");

         property p_level_onehot;
            $onehot0(tl[g*NSTEP +: NSTEP]) && (run[g] == (|tl[g*NSTEP +: NSTEP]));
         endproperty
         a_level_onehot: assert property (p_level_onehot) else $error("time level decode broken");
      end
   endgenerate

   c_start: cover property (|grant);
   c_gated: cover property (|gated_pulse);
   c_sync: cover property ($rose(|s.slvl));
   c_restart: cover property (|(grant & wrap));
endmodule

//--- sim/cit_elem_model.sv
// Model of the storage elements that the gated driver pulses act on.
// Assumes one-cycle gated pulses on the same clock as the timing block.
`timescale 1ns/100ps
module cit_elem_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [cit_pkg::NCNT*cit_pkg::STEPS-1:0] gated_pulse,
   output logic [15:0] events
);
   // event per pulse
   // Only gated pulses change stored state, so the count shows every launched event.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         events <= 16'h0000;
      end else begin
         events <= events + 16'($countones(gated_pulse));
      end
   end
endmodule

//--- sim/counter_interlock_timing_bench.sv
// Self-checking bench for the counter and interlock timing block.
// Assumes the package defaults: three counters, 40 cycles per time level.
`timescale 1ns/100ps
module counter_interlock_timing_bench;
   localparam int W = cit_pkg::NCNT * cit_pkg::STEPS;
   localparam int PER = cit_pkg::LEVEL_CYC;
   logic clk, sys_rst, clock_pulse;
   logic [cit_pkg::NCNT-1:0] req, ev_async, cnt_busy, interlock, sync_lvl;
   logic [W-1:0] ctl_lvl, time_lvl, gated_pulse, exp_val[$];
   logic [15:0] events;
   logic [6:0] mask;
   int errors, checks_done, cyc, last_pulse, t0, nexp, exp_cyc[$];

   cit_timing cit_timing_inst (.clk(clk), .sys_rst(sys_rst), .req(req), .ev_async(ev_async), .ctl_lvl(ctl_lvl),
      .clock_pulse(clock_pulse), .time_lvl(time_lvl), .gated_pulse(gated_pulse), .cnt_busy(cnt_busy),
      .interlock(interlock), .sync_lvl(sync_lvl));
   cit_elem_model cit_elem_model_inst (.clk(clk), .sys_rst(sys_rst), .gated_pulse(gated_pulse), .events(events));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic wait_busy(input int c, input logic v, input int lim);
      int n;
      n = 0;
      while (cnt_busy[c] !== v && n < lim) begin
         step();
         n++;
      end
      check(32'(cnt_busy[c]), 32'(v));
   endtask
   // One full counter cycle with a random control mask; gated pulses are noted for the watcher.
   task automatic run_one(input int c, input logic [6:0] m);
      ctl_lvl[c*7 +: 7] = m;
      req[c] = 1'b1;
      step();
      req[c] = 1'b0;
      check(32'(interlock[c]), 32'h1);
      wait_busy(c, 1'b1, 100);
      t0 = cyc;
      check(32'(time_lvl[c*7 +: 7]), 32'h1);
      check(32'(interlock[c]), 32'h0);
      for (int k = 0; k < 7; k++) begin
         if (m[k]) begin
            exp_val.push_back(W'(1) << (c*7 + k));
            exp_cyc.push_back(t0 + PER*(k + 1));
         end
      end
      nexp += $countones(m);
      repeat (PER*7 - 1) step();
      check(32'(time_lvl[c*7 +: 7]), 32'h40);
      step();
      check(32'({cnt_busy[c], time_lvl[c*7 +: 7]}), 32'h0);
      ctl_lvl = '0;
   endtask

   // ----------------------------------------------------------------
   // Clock, cycle count and hang limit
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc >= 20000) begin
         errors++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Watcher
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      #2;
      if (clock_pulse === 1'b1) begin
         if (last_pulse > 0) check(32'(cyc - last_pulse), 32'(PER));
         last_pulse = cyc;
      end
      if ((cnt_busy[0] & cnt_busy[1]) !== 1'b0) check(32'(cnt_busy), 32'h0);
      if (gated_pulse !== '0) begin
         if (exp_val.size() == 0) check(32'(gated_pulse), 32'h0);
         else begin
            check(32'(gated_pulse), 32'(exp_val.pop_front()));
            check(32'(cyc), 32'(exp_cyc.pop_front()));
         end
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      req = '0;
      ev_async = '0;
      ctl_lvl = '0;
      void'($urandom(43198));
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      check(32'({cnt_busy, interlock, sync_lvl}), 32'h0);
      check(32'(time_lvl | gated_pulse), 32'h0);
      for (int c = 0; c < 3; c++) begin
         mask = 7'($urandom) | 7'h01;
         run_one(c, mask);
      end
      // The last step's pulse is counted by the model one edge later.
      step();
      check(32'(events), 32'(nexp));
      // Same-pulse requests on separate devices: the lower index goes first.
      req = 3'b101;
      step();
      req = '0;
      wait_busy(0, 1'b1, 100);
      repeat (39) step();
      check(32'(cnt_busy[2]), 32'h0);
      step();
      check(32'(cnt_busy[2]), 32'h1);
      repeat (300) step();
      // Two counters sharing one device; the watcher flags any overlap.
      req = 3'b011;
      step();
      req = '0;
      wait_busy(1, 1'b1, 400);
      wait_busy(1, 1'b0, 400);
      // A held request makes the counter wrap from step 6 straight to step 0.
      req[2] = 1'b1;
      wait_busy(2, 1'b1, 100);
      repeat (PER*7) step();
      check(32'({cnt_busy[2], time_lvl[14 +: 7]}), 32'h81);
      req[2] = 1'b0;
      wait_busy(2, 1'b0, 1000);
      // Outside event, raised at a random point of the pulse period.
      repeat ($urandom % 30) step();
      ev_async[1] = 1'b1;
      step();
      ev_async[1] = 1'b0;
      step();
      while (sync_lvl[1] !== 1'b1 && cyc < 19000) step();
      check(32'(cyc - last_pulse), 32'h1);
      repeat (PER - 1) step();
      check(32'(sync_lvl[1]), 32'h1);
      step();
      check(32'(sync_lvl[1]), 32'h0);
      wait_busy(1, 1'b1, 100);
      // Second reset while a counter runs.
      sys_rst = 1'b1;
      step();
      check(32'({cnt_busy, interlock, time_lvl}), 32'h0);
      sys_rst = 1'b0;
      last_pulse = 0;
      repeat (100) step();
      check(32'(cnt_busy | interlock), 32'h0);
      check(32'(exp_val.size()), 32'h0);
      results();
   end
endmodule
